// >>> vdac_pkg.sv
// package: register map, field layout and constants of the dead-band autocalibration block
package vdac_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_START = 8'h04;
    localparam logic [7:0] REG_STEP = 8'h08;
    localparam logic [7:0] REG_THRESH = 8'h0c;
    localparam logic [7:0] REG_INTERVAL = 8'h10;
    localparam logic [7:0] REG_MARGIN = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_RESULT_R = 8'h1c;
    localparam logic [7:0] REG_RESULT_L = 8'h20;
    localparam logic [7:0] REG_FULL_R = 8'h24;
    localparam logic [7:0] REG_FULL_L = 8'h28;
    localparam logic [7:0] REG_PARAM = 8'h2c;
    localparam logic [7:0] REG_MONITOR = 8'h30;
    localparam logic [7:0] REG_FLOW = 8'h34;
    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    localparam int CTRL_BEGIN_BIT = 0;
    localparam int CTRL_CALMODE_BIT = 1;
    localparam int CTRL_DETAIL_BIT = 2;
    localparam int CTRL_FLOWREQ_BIT = 3;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam int MARGIN_INDEX = 758;
    localparam logic [15:0] MARGIN_DEFAULT = 16'd25;
    localparam logic [15:0] MARGIN_MAX = 16'd300;
    localparam logic [15:0] START_DEFAULT = 16'd50;
    localparam logic [15:0] STEP_DEFAULT = 16'd5;
    localparam logic [15:0] THRESH_DEFAULT = 16'd20;
    localparam logic [15:0] INTERVAL_DEFAULT = 16'd500;
    localparam logic [15:0] DB_DEFAULT = 16'd0;
    localparam logic [15:0] FULL_DEFAULT = 16'd1000;
    // ------------------------------------------------------------
    // timing: one millisecond time base
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    // ------------------------------------------------------------
    // progress codes
    // ------------------------------------------------------------
    localparam logic [3:0] ST_IDLE = 4'h0;
    localparam logic [3:0] ST_RIGHT = 4'h1;
    localparam logic [3:0] ST_LEFT = 4'h2;
    localparam logic [3:0] ST_COMMIT = 4'h3;
    localparam logic [3:0] ST_DONE = 4'h4;
    localparam logic [3:0] ST_ABORT = 4'h5;
    localparam logic [3:0] ST_NOFLOW = 4'h6;
    localparam logic [3:0] ST_REFUSED = 4'h7;

    typedef enum logic [2:0] {
        S_IDLE, S_LOAD, S_WAIT, S_STORE, S_COMMIT, S_END
    } vdac_state_t;
endpackage

// >>> vdac_top.sv
// module: dead-band autocalibration sequencer with an APB register file
`timescale 1ns/100ps
module vdac_top #(
    parameter int SP_MAX = 1000,
    parameter int MS_DIV = vdac_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] wheel_pos,
    input wire logic wheel_moving,
    output logic [15:0] spool_setpoint,
    output logic spool_drive,
    output logic [3:0] progress_code,
    output logic progress_pulse,
    output logic nv_write
);
    import vdac_pkg::*;

    // elaboration check: set-point and time base must fit their counters
    if (SP_MAX < 1 || SP_MAX > 65535 || MS_DIV < 1) begin : g_param_check
        $error("vdac_top: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [15:0] pos_m_r, pos_s_r;
    logic mov_m_r, mov_s_r;
    // two stages; only the second is read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_m_r <= 16'h0000;
            pos_s_r <= 16'h0000;
            mov_m_r <= 1'b0;
            mov_s_r <= 1'b0;
        end else begin
            pos_m_r <= wheel_pos;
            pos_s_r <= pos_m_r;
            mov_m_r <= wheel_moving;
            mov_s_r <= mov_m_r;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vdac_state_t state_r, state_nxt;
    logic dir_left_r, dir_left_nxt;
    logic calmode_r, calmode_nxt;
    logic detail_r, detail_nxt;
    logic flowreq_r, flowreq_nxt;
    logic [15:0] start_r, start_nxt, step_r, step_nxt, thresh_r, thresh_nxt;
    logic [15:0] intv_r, intv_nxt, margin_r, margin_nxt, flow_r, flow_nxt;
    logic [15:0] sp_r, sp_nxt, ref_pos_r, ref_pos_nxt;
    logic [15:0] cap_r, cap_nxt;
    logic [15:0] db_r_r, db_r_nxt, db_l_r, db_l_nxt;
    logic [15:0] full_r_r, full_r_nxt, full_l_r, full_l_nxt;
    logic [15:0] act_db_r_r, act_db_l_r;
    logic [31:0] div_r, div_nxt;
    logic [15:0] ms_r, ms_nxt;
    logic [3:0] code_r, code_nxt;
    logic pulse_r, pulse_nxt, nvw_r, nvw_nxt, drive_r, drive_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ready_r, ready_nxt, err_r, err_nxt;

    logic running;
    logic [15:0] delta;
    logic [16:0] sp_sum;
    logic wr, rd, param_reg;
    assign running = (state_r != S_IDLE) && (state_r != S_END);
    assign wr = psel && penable && pwrite && !ready_r;
    assign rd = psel && penable && !pwrite && !ready_r;
    assign param_reg = (paddr == REG_START) || (paddr == REG_STEP) ||
        (paddr == REG_THRESH) || (paddr == REG_INTERVAL) || (paddr == REG_MARGIN);
    // absolute position change over one interval
    assign delta = (pos_s_r >= ref_pos_r) ? pos_s_r - ref_pos_r : ref_pos_r - pos_s_r;
    assign sp_sum = {1'b0, sp_r} + {1'b0, step_r};

    // ------------------------------------------------------------
    // next-state logic for sequencer and registers
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        dir_left_nxt = dir_left_r;
        calmode_nxt = calmode_r;
        detail_nxt = detail_r;
        flowreq_nxt = flowreq_r;
        start_nxt = start_r;
        step_nxt = step_r;
        thresh_nxt = thresh_r;
        intv_nxt = intv_r;
        margin_nxt = margin_r;
        flow_nxt = flow_r;
        sp_nxt = sp_r;
        ref_pos_nxt = ref_pos_r;
        cap_nxt = cap_r;
        db_r_nxt = db_r_r;
        db_l_nxt = db_l_r;
        full_r_nxt = full_r_r;
        full_l_nxt = full_l_r;
        div_nxt = div_r;
        ms_nxt = ms_r;
        code_nxt = code_r;
        pulse_nxt = 1'b0;
        nvw_nxt = 1'b0;
        drive_nxt = drive_r;
        rdata_nxt = 32'h00000000;
        ready_nxt = psel && penable && !ready_r;
        err_nxt = 1'b0;

        // bus writes; parameter access is refused with an error while running
        if (wr) begin
            if (param_reg && running) begin
                err_nxt = 1'b1;
            end else begin
                case (paddr)
                    REG_CTRL: begin
                        calmode_nxt = pwdata[CTRL_CALMODE_BIT];
                        detail_nxt = pwdata[CTRL_DETAIL_BIT];
                        flowreq_nxt = pwdata[CTRL_FLOWREQ_BIT] && pwdata[CTRL_CALMODE_BIT];
                        // begin only in calibration mode and when not running (S_IDLE or S_END)
                        if (pwdata[CTRL_BEGIN_BIT]) begin
                            if (calmode_r && state_r != S_LOAD && !running) begin
                                state_nxt = S_LOAD;
                                dir_left_nxt = 1'b0; // right first
                                flowreq_nxt = 1'b0;
                            end else begin
                                code_nxt = ST_REFUSED;
                                pulse_nxt = 1'b1;
                            end
                        end
                    end
                    REG_START: start_nxt = pwdata[15:0];
                    REG_STEP: step_nxt = pwdata[15:0];
                    REG_THRESH: thresh_nxt = pwdata[15:0];
                    REG_INTERVAL: intv_nxt = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
                    // out-of-range margin refused
                    REG_MARGIN: begin
                        if (pwdata[15:0] <= MARGIN_MAX) begin
                            margin_nxt = pwdata[15:0];
                        end else begin
                            err_nxt = 1'b1;
                        end
                    end
                    REG_FLOW: flow_nxt = pwdata[15:0];
                    default: err_nxt = 1'b1;
                endcase
            end
        end

        // flow request drives the valve in calibration mode when not running (S_IDLE or S_END)
        if (!running && state_nxt != S_LOAD) begin
            drive_nxt = calmode_nxt && flowreq_nxt;
            sp_nxt = (calmode_nxt && flowreq_nxt) ? flow_nxt : 16'h0000;
        end

        // millisecond time base
        if (state_r == S_WAIT) begin
            if (div_r == 32'(MS_DIV - 1)) begin
                div_nxt = 32'h00000000;
                ms_nxt = ms_r + 16'h0001;
            end else begin
                div_nxt = div_r + 32'h00000001;
            end
        end

        case (state_r)
            S_IDLE: ;
            S_LOAD: begin
                sp_nxt = start_r;
                drive_nxt = 1'b1;
                ref_pos_nxt = pos_s_r;
                div_nxt = 32'h00000000;
                ms_nxt = 16'h0000;
                code_nxt = dir_left_r ? ST_LEFT : ST_RIGHT;
                pulse_nxt = 1'b1;
                state_nxt = S_WAIT;
            end
            S_WAIT: begin
                if (div_r == 32'(MS_DIV - 1) && ms_r + 16'h0001 >= intv_r) begin
                    ms_nxt = 16'h0000;
                    ref_pos_nxt = pos_s_r; // next interval's reference
                    if (delta > thresh_r) begin
                        cap_nxt = sp_r;
                        state_nxt = S_STORE;
                    end else if (sp_sum > 17'(SP_MAX)) begin
                        code_nxt = ST_NOFLOW;
                        pulse_nxt = 1'b1;
                        drive_nxt = 1'b0;
                        sp_nxt = 16'h0000;
                        state_nxt = S_END;
                    end else begin
                        sp_nxt = sp_sum[15:0];
                        pulse_nxt = detail_r; // set-point change reported only in detail mode
                    end
                end
            end
            S_STORE: begin
                // dead-band and equal full-flow shift
                if (dir_left_r) begin
                    db_l_nxt = (cap_r > margin_r) ? cap_r - margin_r : 16'h0000;
                    full_l_nxt = full_l_r + db_l_nxt - db_l_r;
                    state_nxt = S_COMMIT;
                end else begin
                    db_r_nxt = (cap_r > margin_r) ? cap_r - margin_r : 16'h0000;
                    full_r_nxt = full_r_r + db_r_nxt - db_r_r;
                    dir_left_nxt = 1'b1;
                    state_nxt = S_LOAD;
                end
                nvw_nxt = 1'b1;
                drive_nxt = 1'b0;
                sp_nxt = 16'h0000;
            end
            S_COMMIT: begin
                nvw_nxt = 1'b1; // automatic commit
                code_nxt = ST_DONE;
                pulse_nxt = 1'b1;
                state_nxt = S_END;
            end
            S_END: ; // calibration mode kept until power cycle
            default: state_nxt = S_IDLE;
        endcase

        // wheel movement aborts at once in every running state except S_COMMIT
        if (running && state_r != S_COMMIT && mov_s_r) begin
            state_nxt = S_END;
            code_nxt = ST_ABORT;
            pulse_nxt = 1'b1;
            drive_nxt = 1'b0;
            sp_nxt = 16'h0000;
        end
        calmode_nxt = calmode_nxt || (state_nxt != S_IDLE);

        // bus reads
        if (rd) begin
            if (param_reg && running) begin
                err_nxt = 1'b1;
            end else begin
                case (paddr)
                    REG_CTRL: rdata_nxt = {28'h0000000, flowreq_r, detail_r, calmode_r, 1'b0};
                    REG_START: rdata_nxt = {16'h0000, start_r};
                    REG_STEP: rdata_nxt = {16'h0000, step_r};
                    REG_THRESH: rdata_nxt = {16'h0000, thresh_r};
                    REG_INTERVAL: rdata_nxt = {16'h0000, intv_r};
                    REG_MARGIN: rdata_nxt = {16'h0000, margin_r};
                    REG_STATUS: rdata_nxt = {24'h000000, 1'b0, 3'(state_r), code_r};
                    REG_RESULT_R: rdata_nxt = {16'h0000, db_r_r};
                    REG_RESULT_L: rdata_nxt = {16'h0000, db_l_r};
                    REG_FULL_R: rdata_nxt = {16'h0000, full_r_r};
                    REG_FULL_L: rdata_nxt = {16'h0000, full_l_r};
                    REG_PARAM: rdata_nxt = {act_db_l_r, act_db_r_r};
                    // detail set one: sensor and set-point
                    REG_MONITOR: rdata_nxt = detail_r ? {pos_s_r, sp_r} : 32'h00000000;
                    REG_FLOW: rdata_nxt = {16'h0000, flow_r};
                    default: err_nxt = 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            dir_left_r <= 1'b0;
            calmode_r <= 1'b0;
            detail_r <= 1'b0;
            flowreq_r <= 1'b0;
            start_r <= START_DEFAULT;
            step_r <= STEP_DEFAULT;
            thresh_r <= THRESH_DEFAULT;
            intv_r <= INTERVAL_DEFAULT;
            margin_r <= MARGIN_DEFAULT;
            flow_r <= 16'h0000;
            sp_r <= 16'h0000;
            ref_pos_r <= 16'h0000;
            cap_r <= 16'h0000;
            db_r_r <= DB_DEFAULT;
            db_l_r <= DB_DEFAULT;
            full_r_r <= FULL_DEFAULT;
            full_l_r <= FULL_DEFAULT;
            div_r <= 32'h00000000;
            ms_r <= 16'h0000;
            code_r <= ST_IDLE;
            pulse_r <= 1'b0;
            nvw_r <= 1'b0;
            drive_r <= 1'b0;
            rdata_r <= 32'h00000000;
            ready_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dir_left_r <= dir_left_nxt;
            calmode_r <= calmode_nxt;
            detail_r <= detail_nxt;
            flowreq_r <= flowreq_nxt;
            start_r <= start_nxt;
            step_r <= step_nxt;
            thresh_r <= thresh_nxt;
            intv_r <= intv_nxt;
            margin_r <= margin_nxt;
            flow_r <= flow_nxt;
            sp_r <= sp_nxt;
            ref_pos_r <= ref_pos_nxt;
            cap_r <= cap_nxt;
            db_r_r <= db_r_nxt;
            db_l_r <= db_l_nxt;
            full_r_r <= full_r_nxt;
            full_l_r <= full_l_nxt;
            div_r <= div_nxt;
            ms_r <= ms_nxt;
            code_r <= code_nxt;
            pulse_r <= pulse_nxt;
            nvw_r <= nvw_nxt;
            drive_r <= drive_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            err_r <= err_nxt;
        end
    end

    // active dead-bands latched once after power-up only
    logic latched_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_r <= 1'b0;
            act_db_r_r <= 16'h0000;
            act_db_l_r <= 16'h0000;
        end else if (!latched_r) begin
            latched_r <= 1'b1;
            act_db_r_r <= db_r_r;
            act_db_l_r <= db_l_r;
        end
    end

    assign prdata = rdata_r;
    assign pready = ready_r;
    assign pslverr = err_r;
    assign spool_setpoint = sp_r;
    assign spool_drive = drive_r;
    assign progress_code = code_r;
    assign progress_pulse = pulse_r;
    assign nv_write = nvw_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_load;
        state_r == S_LOAD;
    endsequence
    a_load_start_sp: assert property (@(posedge pclk) disable iff (!presetn)
        s_load ##0 !mov_s_r |=> (sp_r == $past(start_r)) && drive_r)
        else $error("set-point not loaded from start value");
    a_step_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_WAIT && state_nxt == S_WAIT && sp_nxt != sp_r && !mov_s_r)
        |=> sp_r == $past(sp_r) + $past(step_r))
        else $error("set-point not raised by step size");
    a_detect_capture: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_WAIT && state_nxt == S_STORE) |=> cap_r == $past(sp_r))
        else $error("detected set-point not captured");
    a_margin_range: assert property (@(posedge pclk) disable iff (!presetn)
        margin_r <= MARGIN_MAX)
        else $error("margin out of range");
    a_dead_band: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_STORE && !dir_left_r && cap_r > margin_r)
        |=> db_r_r == $past(cap_r) - $past(margin_r) && nv_write)
        else $error("right dead-band wrong");
    a_full_shift: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_STORE && !dir_left_r) |=>
        full_r_r - db_r_r == $past(full_r_r) - $past(db_r_r))
        else $error("full-flow slope not kept");
    a_right_then_left: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_STORE && !dir_left_r && !mov_s_r) |=> s_load ##0 dir_left_r)
        else $error("left search not started");
    a_auto_commit: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_COMMIT) |=> nv_write && progress_code == ST_DONE)
        else $error("commit or completion missing");
    a_abort_wheel: assert property (@(posedge pclk) disable iff (!presetn)
        (running && state_r != S_COMMIT && mov_s_r) |=> state_r == S_END && !spool_drive)
        else $error("wheel movement did not abort");
    a_stay_calmode: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == S_END) |=> state_r == S_END && calmode_r)
        else $error("left calibration mode");
    a_refuse_begin: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == REG_CTRL && pwdata[CTRL_BEGIN_BIT] && !calmode_r)
        |=> state_r == S_IDLE && progress_code == ST_REFUSED)
        else $error("begin accepted outside calibration mode");
endmodule // vdac_top

// >>> vdac_valve_model.sv
// partner model: valve and wheel angle sensor answering the spool set-point
`timescale 1ns/100ps
module vdac_valve_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] spool_setpoint,
    input wire logic spool_drive,
    input wire logic [15:0] flow_at,
    output logic [15:0] wheel_pos
);
    // wheel creeps a count a cycle once the spool passes the flow point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wheel_pos <= 16'h0000;
        end else if (spool_drive && spool_setpoint >= flow_at) begin
            wheel_pos <= wheel_pos + 16'h0001;
        end
    end
endmodule // vdac_valve_model

// >>> tb.sv
// testbench: dead-band search, refusals, abort and no-flow runs
`timescale 1ns/100ps
module tb;
    import vdac_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wheel_moving = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, spool_drive, progress_pulse, nv_write, err;
    logic [15:0] wheel_pos, spool_setpoint, flow_at = 16'hffff;
    logic [3:0] progress_code;
    int n_mismatch = 0, num_checks = 0, seed = 32'h8a33e51c, cap, db, n_nv = 0, n_pp = 0;
    vdac_top #(.SP_MAX(300), .MS_DIV(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wheel_pos(wheel_pos), .wheel_moving(wheel_moving),
        .spool_setpoint(spool_setpoint), .spool_drive(spool_drive),
        .progress_code(progress_code), .progress_pulse(progress_pulse), .nv_write(nv_write));
    vdac_valve_model u_valve (.pclk(pclk), .presetn(presetn), .spool_setpoint(spool_setpoint),
        .spool_drive(spool_drive), .flow_at(flow_at), .wheel_pos(wheel_pos));
    initial forever #2.5 pclk = ~pclk;
    // pulse counters, cleared by the main sequence before the first run only
    always @(posedge pclk) begin
        if (nv_write === 1'b1) n_nv++;
        if (progress_pulse === 1'b1) n_pp++;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // bounded wait for a final progress code
    task wait_end();
        repeat (50000) begin
            @(posedge pclk);
            if (progress_code inside {ST_DONE, ST_ABORT, ST_NOFLOW}) break;
        end
        // one more edge so the pulse counters have seen the final pulse
        @(posedge pclk);
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hang guard: far beyond the longest run
    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        do_reset();
        chk("spool drive", 32'h0, {31'h0, spool_drive});
        apb(1'b0, REG_MARGIN, 32'h0);
        chk("margin reset", 32'd25, rd);
        apb(1'b1, REG_MARGIN, 32'd301);
        chk("margin range", 32'h1, {31'h0, err});
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("begin refused", {28'h0, ST_REFUSED}, {28'h0, rd[3:0]});
        flow_at <= 16'd60 + 16'($random(seed) & 32'h1f);
        apb(1'b1, REG_INTERVAL, 32'd500);
        apb(1'b1, REG_CTRL, 32'h2);
        n_nv = 0;
        n_pp = 0;
        apb(1'b1, REG_CTRL, 32'h3);
        apb(1'b0, REG_START, 32'h0);
        chk("param locked", 32'h1, {31'h0, err});
        wait_end();
        cap = 50 + ((int'(flow_at) - 50 + 4) / 5) * 5;
        db = cap - 25; // margin left at default
        chk("done code", {28'h0, ST_DONE}, {28'h0, progress_code});
        chk("nv writes", 32'd3, n_nv);
        chk("progress seen", 32'h1, {31'h0, n_pp != 0});
        apb(1'b0, REG_RESULT_R, 32'h0);
        chk("deadband r", db, rd);
        apb(1'b0, REG_RESULT_L, 32'h0);
        chk("deadband l", db, rd);
        apb(1'b0, REG_FULL_R, 32'h0);
        chk("full flow r", 1000 + db, rd);
        apb(1'b0, REG_FULL_L, 32'h0);
        chk("full flow l", 1000 + db, rd);
        apb(1'b0, REG_PARAM, 32'h0);
        chk("active deadband", 32'h0, rd);
        apb(1'b0, REG_CTRL, 32'h0);
        chk("calmode kept", 32'h1, {31'h0, rd[1]});
        apb(1'b1, REG_FLOW, 32'd77);
        apb(1'b1, REG_CTRL, 32'he);
        repeat (3) @(posedge pclk);
        chk("flow request", 32'd77, {16'h0, spool_setpoint});
        apb(1'b0, REG_MONITOR, 32'h0);
        chk("monitor setpoint", 32'd77, {16'h0, rd[15:0]});
        // abort run: no flow ever, wheel turned mid-search
        do_reset();
        flow_at <= 16'hffff;
        apb(1'b1, REG_CTRL, 32'h2);
        apb(1'b1, REG_CTRL, 32'h3);
        repeat (20 + ($random(seed) & 32'hf)) @(posedge pclk);
        wheel_moving <= 1'b1;
        wait_end();
        chk("abort code", {28'h0, ST_ABORT}, {28'h0, progress_code});
        wheel_moving <= 1'b0;
        // coarse steps so the set-point hits its ceiling quickly
        do_reset();
        apb(1'b1, REG_STEP, 32'd50);
        apb(1'b1, REG_INTERVAL, 32'd2);
        apb(1'b1, REG_CTRL, 32'h2);
        apb(1'b1, REG_CTRL, 32'h3);
        wait_end();
        chk("no flow code", {28'h0, ST_NOFLOW}, {28'h0, progress_code});
        summarize();
    end
endmodule // tb
